// ---- core/adc_mux_pkg.sv ----
// Constants, types and register map for the converter selection block
package adc_mux_pkg;

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL_B  = 6'h03;
  localparam logic [5:0] IDX_RES_LO  = 6'h04;
  localparam logic [5:0] IDX_RES_HI  = 6'h05;
  localparam logic [5:0] IDX_CHREF   = 6'h07;
  localparam logic [5:0] IDX_STATUS  = 6'h08;

  localparam logic [7:0] CHREF_RST   = 8'h00;
  localparam logic [7:0] CTRL_B_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIPOLAR_BIT  = 7;
  localparam int unsigned REF_HI       = 7;
  localparam int unsigned REF_LO       = 6;
  localparam int unsigned CHAN_HI      = 5;
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_PENDING   = 1;
  localparam int unsigned ST_DIFF      = 2;
  localparam int unsigned ST_APPLIED_LO = 8;

  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CH_GND      = 6'h20;
  localparam logic [5:0] CH_IREF     = 6'h21;
  localparam logic [5:0] CH_TEMP     = 6'h22;
  localparam logic [5:0] CH_CAL0     = 6'h23;
  localparam logic [5:0] CH_CAL3_LO  = 6'h24;
  localparam logic [5:0] CH_CAL3_HI  = 6'h25;
  localparam logic [5:0] CH_CAL7_LO  = 6'h26;
  localparam logic [5:0] CH_CAL7_HI  = 6'h27;

  typedef enum logic [1:0] {
    REF_SUPPLY   = 2'h0,
    REF_EXTERNAL = 2'h1,
    REF_INTERNAL = 2'h2,
    REF_RESERVED = 2'h3
  } ref_t;

  // ----------------------------------------------------------------
  // Result coding
  // ----------------------------------------------------------------
  localparam int unsigned RES_W    = 10;
  localparam int unsigned SAMPLE_W = 12;
  localparam logic signed [11:0] UNI_TOP = 12'sh3FF;
  localparam logic signed [11:0] BIP_TOP = 12'sh1FF;
  localparam logic signed [11:0] BIP_BOT = 12'shE00;
  localparam logic [9:0] UNI_MAX   = 10'h3FF;
  localparam logic [9:0] UNI_MIN   = 10'h000;
  localparam logic [9:0] BIP_MAX   = 10'h1FF;
  localparam logic [9:0] BIP_MIN   = 10'h200;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       busy;
    logic                       done;
    logic signed [SAMPLE_W-1:0] sample;
  } conv_in_t;

  typedef struct packed {
    ref_t       ref_sel;
    logic       ref_pin_drive;
    logic       int_ref_on;
    logic       ext_ref_used;
    logic       diff;
    logic       gain20;
    logic [2:0] pos;
    logic [2:0] neg;
    logic       gnd_sel;
    logic       iref_sel;
    logic       temp_en;
  } analog_sel_t;

endpackage

// ---- core/adc_sel_decode.sv ----
// Decoder from the selection register to analog switch controls
`timescale 1ns/100ps
module adc_sel_decode (
  input  wire logic [7:0]               i_chref,
  output adc_mux_pkg::analog_sel_t      o_sel
);
  import adc_mux_pkg::*;

  logic [5:0] chan;
  logic [2:0] p;
  logic [2:0] n;

  assign chan = i_chref[CHAN_HI:0];

  // ----------------------------------------------------------------
  // Pair table indexed by channel bits 4:1
  // ----------------------------------------------------------------
  always_comb begin
    p = 3'h0;
    n = 3'h0;
    case (chan[4:1])
      4'h4: begin p = 3'h0; n = 3'h1; end
      4'h5: begin p = 3'h0; n = 3'h3; end
      4'h6: begin p = 3'h1; n = 3'h2; end
      4'h7: begin p = 3'h1; n = 3'h3; end
      4'h8: begin p = 3'h2; n = 3'h3; end
      4'h9: begin p = 3'h3; n = 3'h4; end
      4'hA: begin p = 3'h3; n = 3'h5; end
      4'hB: begin p = 3'h3; n = 3'h6; end
      4'hC: begin p = 3'h3; n = 3'h7; end
      4'hD: begin p = 3'h4; n = 3'h5; end
      4'hE: begin p = 3'h5; n = 3'h6; end
      4'hF: begin p = 3'h6; n = 3'h7; end
      default: begin p = 3'h0; n = 3'h0; end
    endcase
  end

  always_comb begin
    o_sel               = '0;
    o_sel.ref_sel       = ref_t'(i_chref[REF_HI:REF_LO]);
    o_sel.ext_ref_used  = (o_sel.ref_sel == REF_EXTERNAL);
    o_sel.int_ref_on    = o_sel.ref_sel[1];
    o_sel.ref_pin_drive = (o_sel.ref_sel == REF_RESERVED);
    if (chan[5:3] == 3'h0) begin
      o_sel.pos = chan[2:0];
    end else if (chan == CH_GND) begin
      o_sel.gnd_sel = 1'b1;
    end else if (chan == CH_IREF) begin
      o_sel.iref_sel = 1'b1;
    end else if (chan == CH_TEMP) begin
      o_sel.temp_en = 1'b1;
    end else if (chan[5:3] == 3'h4) begin
      o_sel.diff   = 1'b1;
      o_sel.gain20 = chan[0];
      if (chan == CH_CAL3_LO || chan == CH_CAL3_HI) begin
        o_sel.pos = 3'h3;
        o_sel.neg = 3'h3;
      end else if (chan == CH_CAL7_LO || chan == CH_CAL7_HI) begin
        o_sel.pos = 3'h7;
        o_sel.neg = 3'h7;
      end
    end else begin
      o_sel.diff   = 1'b1;
      o_sel.gain20 = chan[0];
      o_sel.pos    = chan[CHAN_HI] ? n : p;
      o_sel.neg    = chan[CHAN_HI] ? p : n;
    end
  end

endmodule

// ---- core/adc_result_coder.sv ----
// Coding of the converter sample into the 10-bit result
`timescale 1ns/100ps
module adc_result_coder (
  input  wire logic signed [11:0] i_sample,
  input  wire logic               i_bipolar,
  output logic [9:0]              o_code
);
  import adc_mux_pkg::*;

  logic signed [11:0] half;

  assign half = i_sample >>> 1;

  always_comb begin
    if (i_bipolar) begin
      if (half > BIP_TOP) begin
        o_code = BIP_MAX;
      end else if (half < BIP_BOT) begin
        o_code = BIP_MIN;
      end else begin
        o_code = half[9:0];
      end
    end else begin
      if (i_sample < 12'sh000) begin
        o_code = UNI_MIN;
      end else if (i_sample > UNI_TOP) begin
        o_code = UNI_MAX;
      end else begin
        o_code = i_sample[9:0];
      end
    end
  end

endmodule

// ---- core/adc_mux_ref_result_format.sv ----
// Channel, gain and reference selection with result coding
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module adc_mux_ref_result_format (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic                      o_pready,
  output logic                      o_pslverr,
  output logic [31:0]               o_prdata,
  input  wire adc_mux_pkg::conv_in_t i_conv,
  output adc_mux_pkg::analog_sel_t  o_sel,
  output logic                      o_result_sign,
  output logic                      o_bipolar
);
  import adc_mux_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  chref_shadow;
  logic [7:0]  chref_active;
  logic [7:0]  ctrl_b;
  logic [9:0]  result;
  logic        pending;

  logic [7:0]  next_active;
  logic        next_pending;
  logic [7:0]  next_shadow;
  logic [7:0]  next_ctrl_b;
  logic        next_bipolar;
  logic [9:0]  next_result;
  logic        next_sign;
  logic        code_bipolar;
  logic [7:0]  wr_byte;
  analog_sel_t next_sel;
  logic [9:0]  coded;
  logic        apply_now;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        access;
  logic        rd_phase;
  logic        wr_lane0;
  logic        hit_ctrl_b;
  logic        hit_res_lo;
  logic        hit_res_hi;
  logic        hit_chref;
  logic        hit_status;
  logic        mapped;
  logic        wr_chref;
  logic        wr_ctrl_b;
  logic [31:0] rd_data;
  logic [31:0] status_word;
  logic        next_ready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] ctrl_b_word;
  logic [31:0] res_lo_word;
  logic [31:0] res_hi_word;
  logic [31:0] chref_word;

  assign access   = i_psel & i_penable & o_pready;
  assign rd_phase = i_psel & i_penable & ~o_pready;
  assign wr_lane0 = access & i_pwrite & i_pstrb[0];

  // ----------------------------------------------------------------
  // Byte carried by a register write
  // ----------------------------------------------------------------
  assign wr_byte  = i_pwdata[7:0];

  always_comb begin
    hit_ctrl_b = 1'b0;
    hit_res_lo = 1'b0;
    hit_res_hi = 1'b0;
    hit_chref  = 1'b0;
    hit_status = 1'b0;
    if (i_paddr == {IDX_CTRL_B, 2'b00}) begin
      hit_ctrl_b = 1'b1;
    end else if (i_paddr == {IDX_RES_LO, 2'b00}) begin
      hit_res_lo = 1'b1;
    end else if (i_paddr == {IDX_RES_HI, 2'b00}) begin
      hit_res_hi = 1'b1;
    end else if (i_paddr == {IDX_CHREF, 2'b00}) begin
      hit_chref = 1'b1;
    end else if (i_paddr == {IDX_STATUS, 2'b00}) begin
      hit_status = 1'b1;
    end
  end

  assign mapped    = hit_ctrl_b | hit_res_lo | hit_res_hi | hit_chref | hit_status;
  assign wr_chref  = wr_lane0 & hit_chref;
  assign wr_ctrl_b = wr_lane0 & hit_ctrl_b;

  // ----------------------------------------------------------------
  // Read words of the byte-wide registers
  // ----------------------------------------------------------------
  assign ctrl_b_word = {24'h00_0000, ctrl_b};
  assign res_lo_word = {24'h00_0000, result[7:0]};
  assign res_hi_word = {30'h0000_0000, result[9:8]};
  assign chref_word  = {24'h00_0000, chref_shadow};

  always_comb begin
    status_word                  = 32'h0000_0000;
    status_word[ST_BUSY]         = i_conv.busy;
    status_word[ST_PENDING]      = pending;
    status_word[ST_DIFF]         = o_sel.diff;
    status_word[ST_APPLIED_LO+:8] = chref_active;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl_b) begin
      rd_data = ctrl_b_word;
    end else if (hit_res_lo) begin
      rd_data = res_lo_word;
    end else if (hit_res_hi) begin
      rd_data = res_hi_word;
    end else if (hit_chref) begin
      rd_data = chref_word;
    end else if (hit_status) begin
      rd_data = status_word;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait state, data and error from flops
  // ----------------------------------------------------------------
  always_comb begin
    next_ready   = rd_phase;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (rd_phase) begin
      next_pslverr = ~mapped;
      if (!i_pwrite) begin
        next_prdata = rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= next_ready;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_prdata  <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Converter control b: mode bit and plain stored bits
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl_b = ctrl_b;
    if (wr_ctrl_b) begin
      next_ctrl_b = wr_byte;
    end
  end

  assign next_bipolar = next_ctrl_b[BIPOLAR_BIT];

  // ----------------------------------------------------------------
  // Converter control b storage and mode output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_b <= CTRL_B_RST;
    end else begin
      ctrl_b <= next_ctrl_b;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bipolar <= 1'b0;
    end else begin
      o_bipolar <= next_bipolar;
    end
  end

  // ----------------------------------------------------------------
  // Deferral condition: hold selection while converting
  // ----------------------------------------------------------------
  always_comb begin
    apply_now = 1'b1;
    if (i_conv.busy && !i_conv.done) begin
      apply_now = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Selection register: written value and deferred update
  // ----------------------------------------------------------------
  always_comb begin
    next_shadow = chref_shadow;
    if (wr_chref) begin
      next_shadow = wr_byte;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chref_shadow <= CHREF_RST;
    end else begin
      chref_shadow <= next_shadow;
    end
  end

  always_comb begin
    if (wr_chref && apply_now) begin
      next_active = wr_byte;
    end else if (pending && apply_now) begin
      next_active = chref_shadow;
    end else begin
      next_active = chref_active;
    end
  end

  always_comb begin
    if (wr_chref && !apply_now) begin
      next_pending = 1'b1;
    end else if (apply_now) begin
      next_pending = 1'b0;
    end else begin
      next_pending = pending;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chref_active <= CHREF_RST;
      pending      <= 1'b0;
    end else begin
      chref_active <= next_active;
      pending      <= next_pending;
    end
  end

  adc_sel_decode u_decode (
    .i_chref (next_active),
    .o_sel   (next_sel)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sel <= '0;
    end else begin
      o_sel <= next_sel;
    end
  end

  // ----------------------------------------------------------------
  // Result capture with the selection of the finished conversion
  // ----------------------------------------------------------------
  assign code_bipolar = ctrl_b[BIPOLAR_BIT] & o_sel.diff;

  adc_result_coder u_coder (
    .i_sample  (i_conv.sample),
    .i_bipolar (code_bipolar),
    .o_code    (coded)
  );

  // ----------------------------------------------------------------
  // Result next value, taken only on completion
  // ----------------------------------------------------------------
  always_comb begin
    next_result = result;
    next_sign   = o_result_sign;
    if (i_conv.done) begin
      next_result = coded;
      next_sign   = coded[RES_W-1];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result        <= 10'h000;
      o_result_sign <= 1'b0;
    end else begin
      result        <= next_result;
      o_result_sign <= next_sign;
    end
  end

endmodule

// ---- verification/adc_mux_sva.sv ----
// Port checker for the selection block
`timescale 1ns/100ps
module adc_mux_sva
  import adc_mux_pkg::*;
(
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic                     i_psel,
  input wire logic                     i_penable,
  input wire logic                     i_pwrite,
  input wire logic [7:0]               i_paddr,
  input wire logic [31:0]              i_pwdata,
  input wire logic [3:0]               i_pstrb,
  input wire logic                     o_pready,
  input wire logic                     o_pslverr,
  input wire logic [31:0]              o_prdata,
  input wire adc_mux_pkg::conv_in_t    i_conv,
  input wire adc_mux_pkg::analog_sel_t o_sel,
  input wire logic                     o_result_sign,
  input wire logic                     o_bipolar
);
  // ------------------------------------------------
  // Bus decode and properties
  // ------------------------------------------------
  logic acc;
  logic wr_ch;
  logic wr_cb;
  assign acc   = i_psel & i_penable & o_pready;
  assign wr_ch = acc & i_pwrite & i_pstrb[0] & (i_paddr == {IDX_CHREF, 2'b00});
  assign wr_cb = acc & i_pwrite & i_pstrb[0] & (i_paddr == {IDX_CTRL_B, 2'b00});
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ready_wait_a: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  sign_read_a: assert property (acc && !i_pwrite && i_paddr == {IDX_RES_HI, 2'b00} |->
    o_prdata[1] == o_result_sign) else $error("sign output differs from result");
  bipolar_follow_a: assert property (wr_cb |=> o_bipolar == $past(i_pwdata[BIPOLAR_BIT]))
    else $error("bipolar output not updated");
  idle_apply_a: assert property (wr_ch && !i_conv.busy |=> o_sel.ref_sel == $past(i_pwdata[7:6]))
    else $error("idle write not applied");
  busy_hold_a: assert property (i_conv.busy && !i_conv.done |=> $stable(o_sel))
    else $error("selection changed during conversion");
  ref_decode_a: assert property (o_sel.int_ref_on == (o_sel.ref_sel inside {REF_INTERNAL,
    REF_RESERVED}) && o_sel.ext_ref_used == (o_sel.ref_sel == REF_EXTERNAL)
    && o_sel.ref_pin_drive == (o_sel.ref_sel == REF_RESERVED)) else $error("reference decode");
  temp_single_a: assert property (o_sel.temp_en |-> !o_sel.diff && !o_sel.gnd_sel)
    else $error("temperature input not single");
endmodule

// ---- verification/conv_core_model.sv ----
// Behavioural converter core facing the selection block
`timescale 1ns/100ps
module conv_core_model
  import adc_mux_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_start,
  input  wire logic signed [11:0] i_sample,
  input  wire logic [7:0]         i_len,
  output adc_mux_pkg::conv_in_t   o_conv
);
  logic [7:0] left;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left   <= 8'h00;
      o_conv <= '0;
    end else begin
      o_conv.done   <= 1'b0;
      o_conv.sample <= ~o_conv.sample; // Not valid outside done
      if (i_start) begin
        left        <= i_len;
        o_conv.busy <= 1'b1;
      end else if (left == 8'h01) begin
        left          <= 8'h00;
        o_conv.busy   <= 1'b0;
        o_conv.done   <= 1'b1;
        o_conv.sample <= i_sample;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

// ---- verification/adc_mux_ref_result_format_bench.sv ----
// Self-checking bench for the selection block
`timescale 1ns/100ps
module adc_mux_ref_result_format_bench;
  import adc_mux_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  logic [7:0] paddr = 8'h00, len = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rdata, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [11:0] sample = 12'h000;
  logic pready, pslverr, rsign, bip, err;
  logic [10:0] m;
  conv_in_t conv;
  analog_sel_t sel;
  int mismatches = 0, compares = 0, cycles = 0;
  logic [5:0] codes[14] = '{6'h00, 6'h07, 6'h20, 6'h21, 6'h22, 6'h08, 6'h09,
    6'h28, 6'h1F, 6'h3F, 6'h23, 6'h24, 6'h26, 6'h12};
  logic [10:0] exps[14] = '{11'h000, 11'h1C0, 11'h004, 11'h002, 11'h001, 11'h408,
    11'h608, 11'h440, 11'h7B8, 11'h7F0, 11'h600, 11'h4D8, 11'h5F8, 11'h4E0};
  logic [11:0] samp[7] = '{12'hFFB, 12'h7D0, 12'h2BC, 12'hC00, 12'h7D0, 12'hFFA, 12'h064};
  logic [9:0] res[7] = '{10'h000, 10'h3FF, 10'h2BC, 10'h200, 10'h1FF, 10'h3FD, 10'h032};
  always #4 clk = ~clk;
  adc_mux_ref_result_format dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_conv(conv), .o_sel(sel),
    .o_result_sign(rsign), .o_bipolar(bip));
  conv_core_model core (.i_clk(clk), .i_rst(rst), .i_start(start), .i_sample(sample),
    .i_len(len), .o_conv(conv));
  // ------------------------------------------------
  // Bus, converter and compare tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic conv_go(input logic [11:0] s, input logic [7:0] l);
    @(posedge clk);
    sample <= s; len <= l; start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic wait_done();
    do @(posedge clk); while (conv.done !== 1'b1);
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({16'h0000, sel}, 32'h0000_0000);
    chk(bip, 1'b0);
    xfer(1'b0, 8'h1C, 32'h0, 4'h0);
    chk(rdata, CHREF_RST);
    xfer(1'b0, 8'h0C, 32'h0, 4'h0);
    chk(rdata, CTRL_B_RST);
    for (int r = 0; r < 4; r++) begin
      xfer(1'b1, 8'h1C, {24'h0, r[1:0], 6'h05}, 4'h1);
      @(negedge clk);
      chk(sel.ref_sel, r);
      xfer(1'b0, 8'h1C, 32'h0, 4'h0);
      chk(rdata, {24'h0, r[1:0], 6'h05});
    end
    for (int i = 0; i < 14; i++) begin
      xfer(1'b1, 8'h1C, {26'h0, codes[i]}, 4'h1);
      @(negedge clk);
      m = codes[i] < 6'h08 ? 11'h5C7 : (codes[i] inside {[6'h20:6'h22]}) ? 11'h407 : 11'h7FF;
      chk({sel.diff, sel.gain20, sel.pos, sel.neg, sel.gnd_sel, sel.iref_sel, sel.temp_en} & m,
        exps[i] & m);
    end
    xfer(1'b1, 8'h1C, 32'h0000_00FF, 4'h0);
    xfer(1'b0, 8'h1C, 32'h0, 4'h0);
    chk(rdata, 32'h0000_0012);
    xfer(1'b0, 8'h3C, 32'h0, 4'h0);
    chk(rdata, 32'h0000_0000);
    chk(err, 1'b1);
    xfer(1'b1, 8'h1C, 32'h0000_0088, 4'h1);
    repeat (13) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      if (i == 3) begin
        xfer(1'b1, 8'h0C, 32'h0000_0080, 4'h1);
        @(negedge clk);
        chk(bip, 1'b1);
      end
      conv_go(samp[i], 8'd20);
      wait_done();
      xfer(1'b0, 8'h10, 32'h0, 4'h0);
      chk(rdata, {24'h0, res[i][7:0]});
      xfer(1'b0, 8'h14, 32'h0, 4'h0);
      chk(rdata, {30'h0, res[i][9:8]});
      chk(rsign, res[i][9]);
    end
    conv_go(12'h000, 8'd40);
    xfer(1'b1, 8'h1C, 32'h0000_0045, 4'h1);
    @(negedge clk);
    chk(sel.ref_sel, REF_INTERNAL);
    xfer(1'b0, 8'h20, 32'h0, 4'h0);
    chk({rdata[15:8], rdata[1]}, 9'h111);
    wait_done();
    chk(sel.ref_sel, REF_EXTERNAL);
    chk(sel.pos, 3'h5);
    summarize();
  end
endmodule
bind adc_mux_ref_result_format adc_mux_sva chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
  .i_conv(i_conv), .o_sel(o_sel), .o_result_sign(o_result_sign), .o_bipolar(o_bipolar));
